// *** inc/adc_fmt_map.svh ***
// Register offsets, reset values and field positions of the result formatter
`ifndef ADC_FMT_MAP_SVH
`define ADC_FMT_MAP_SVH
`define OFS_UPPER_LIMIT_LOW   8'hC4
`define OFS_UPPER_LIMIT_HIGH  8'hC5
`define OFS_LOWER_LIMIT_LOW   8'hC6
`define OFS_LOWER_LIMIT_HIGH  8'hC7
`define OFS_RESULT_LOW        8'hBE
`define OFS_RESULT_HIGH       8'hBF
`define OFS_CONTROL           8'hE8
`define RST_UPPER_LIMIT       8'hFF
`define RST_LOWER_LIMIT       8'h00
`define RST_RESULT            8'h00
`define CTL_DONE_BIT          5
`define CTL_BUSY_BIT          4
`define CTL_WINDOW_BIT        1
`define CTL_JUSTIFY_BIT       0
`endif

// *** inc/adc_fmt_pkg.sv ***
// Types shared by the result formatter
package adc_fmt_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
endpackage : adc_fmt_pkg

// *** hdl/adc_result_format_window_compare.sv ***
// Converter result formatter with window comparator and its registers
`timescale 1ns/10ps
`include "adc_fmt_map.svh"

module adc_result_format_window_compare #(
  parameter int RESULT_WIDTH = 10
) (
  input  wire logic                     CLOCK,
  input  wire logic                     RST_N,
  // Special-function register port
  input  wire logic [7:0]               SFR_ADDR,
  input  wire logic                     SFR_WR,
  input  wire logic [7:0]               SFR_WDATA,
  output      logic [7:0]               SFR_RDATA,
  // Converter core side
  input  wire logic                     CONVERSION_BUSY,
  input  wire logic [RESULT_WIDTH-1:0]  CONV_RESULT,
  input  wire logic                     DIFFERENTIAL,
  // Status outputs
  output      logic                     WINDOW_COMPARE_FLAG,
  output      logic                     CONVERSION_DONE_FLAG
);

  // Width of the fill that pads a result out to the 16-bit data word
  localparam int PAD_WIDTH = 16 - RESULT_WIDTH;

  // Busy comes from the analog core's own timing, so it is synchronised first
  logic busy_meta_reg;
  logic busy_sync_reg;
  logic busy_last_reg;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
      busy_last_reg <= 1'b0;
    end else begin
      busy_meta_reg <= CONVERSION_BUSY;
      busy_sync_reg <= busy_meta_reg;
      busy_last_reg <= busy_sync_reg;
    end
  end

  // Falling edge of the synchronised busy; history idles low like the pin
  wire logic end_of_conv = busy_last_reg & ~busy_sync_reg;

  // Result code and pairing tag cross from the analog core through two flops too.
  // They are quasi-static around the busy fall, so the word cannot tear: the core
  // holds them for several cycles and the end pulse lands inside that span.
  logic [RESULT_WIDTH-1:0] result_meta_reg;
  logic [RESULT_WIDTH-1:0] result_sync_reg;
  logic                    diff_meta_reg;
  logic                    diff_sync_reg;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      result_meta_reg <= '0;
      result_sync_reg <= '0;
      diff_meta_reg   <= 1'b0;
      diff_sync_reg   <= 1'b0;
    end else begin
      result_meta_reg <= CONV_RESULT;
      result_sync_reg <= result_meta_reg;
      diff_meta_reg   <= DIFFERENTIAL;
      diff_sync_reg   <= diff_meta_reg;
    end
  end

  // Latched result, loaded only by the end-of-conversion pulse
  logic [RESULT_WIDTH-1:0] result_reg;
  logic                    diff_reg;
  wire logic [RESULT_WIDTH-1:0] result_next = end_of_conv ? result_sync_reg : result_reg;
  wire logic                    diff_next   = end_of_conv ? diff_sync_reg : diff_reg;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      result_reg <= '0;
      diff_reg   <= 1'b0;
    end else begin
      result_reg <= result_next;
      diff_reg   <= diff_next;
    end
  end

  // Software-written registers
  adc_fmt_pkg::byte_t upper_limit_low_byte_reg;
  adc_fmt_pkg::byte_t upper_limit_high_byte_reg;
  adc_fmt_pkg::byte_t lower_limit_low_byte_reg;
  adc_fmt_pkg::byte_t lower_limit_high_byte_reg;
  logic               justify_select_reg;
  logic               window_compare_flag_reg;
  logic               conversion_done_flag_reg;

  // Write decode; one strobe per writable register
  wire logic wr_upper_low  = SFR_WR && SFR_ADDR == `OFS_UPPER_LIMIT_LOW;
  wire logic wr_upper_high = SFR_WR && SFR_ADDR == `OFS_UPPER_LIMIT_HIGH;
  wire logic wr_lower_low  = SFR_WR && SFR_ADDR == `OFS_LOWER_LIMIT_LOW;
  wire logic wr_lower_high = SFR_WR && SFR_ADDR == `OFS_LOWER_LIMIT_HIGH;
  wire logic wr_control    = SFR_WR && SFR_ADDR == `OFS_CONTROL;

  // Formatting of the latched result into the 16-bit data word
  wire logic sign_fill = diff_reg & result_reg[RESULT_WIDTH-1];
  wire adc_fmt_pkg::word_t right_word =
    {{PAD_WIDTH{sign_fill}}, result_reg};
  wire adc_fmt_pkg::word_t left_word =
    {result_reg, {PAD_WIDTH{1'b0}}};
  wire adc_fmt_pkg::word_t data_word  = justify_select_reg ? left_word : right_word;

  // Result bytes are formatted at read time, so flipping the justify bit reformats
  // the last result rather than waiting for the next conversion.
  wire adc_fmt_pkg::word_t upper_word = {upper_limit_high_byte_reg, upper_limit_low_byte_reg};
  wire adc_fmt_pkg::word_t lower_word = {lower_limit_high_byte_reg, lower_limit_low_byte_reg};

  // Window evaluation on the synchronised result, the same value the latch catches;
  // it is formatted like the limits with the justify bit in force at that moment
  wire logic new_sign = diff_sync_reg & result_sync_reg[RESULT_WIDTH-1];
  wire adc_fmt_pkg::word_t new_right = {{PAD_WIDTH{new_sign}}, result_sync_reg};
  wire adc_fmt_pkg::word_t new_left  = {result_sync_reg, {PAD_WIDTH{1'b0}}};
  wire adc_fmt_pkg::word_t new_word  = justify_select_reg ? new_left : new_right;

  // Signed view: bit 16 extended for differential, zero for single-ended
  wire logic signed [16:0] res_s = {diff_sync_reg & new_word[15], new_word};
  wire logic signed [16:0] up_s  = {diff_sync_reg & upper_word[15], upper_word};
  wire logic signed [16:0] lo_s  = {diff_sync_reg & lower_word[15], lower_word};

  wire logic above_upper = res_s > up_s;
  wire logic below_lower = res_s < lo_s;
  wire logic inside_mode = lo_s > up_s;
  wire logic window_hit  = inside_mode ? (above_upper & below_lower)
                                       : (above_upper | below_lower);

  // Flags: hardware set wins over a software clear in the same cycle
  wire logic win_set  = end_of_conv & window_hit;
  wire logic win_clr  = wr_control & ~SFR_WDATA[`CTL_WINDOW_BIT];
  wire logic done_clr = wr_control & ~SFR_WDATA[`CTL_DONE_BIT];

  // Next values of the control bits; the set term is ORed in last so a hardware
  // set beats a software clear that lands in the same cycle.
  wire logic window_compare_flag_next =
    win_set | (window_compare_flag_reg & ~win_clr);
  wire logic conversion_done_flag_next =
    end_of_conv | (conversion_done_flag_reg & ~done_clr);
  // Justify select is rewritten on every control write, whatever the flag bits say
  wire logic justify_select_next =
    wr_control ? SFR_WDATA[`CTL_JUSTIFY_BIT] : justify_select_reg;

  // Control bits
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      window_compare_flag_reg  <= 1'b0;
      conversion_done_flag_reg <= 1'b0;
      justify_select_reg       <= 1'b0;
    end else begin
      window_compare_flag_reg  <= window_compare_flag_next;
      conversion_done_flag_reg <= conversion_done_flag_next;
      justify_select_reg       <= justify_select_next;
    end
  end

  // Next values of the limit bytes; there is no locking between the two bytes of a
  // word, so software should not let a conversion end between its two writes.
  wire adc_fmt_pkg::byte_t upper_limit_low_byte_next =
    wr_upper_low ? SFR_WDATA : upper_limit_low_byte_reg;
  wire adc_fmt_pkg::byte_t upper_limit_high_byte_next =
    wr_upper_high ? SFR_WDATA : upper_limit_high_byte_reg;
  wire adc_fmt_pkg::byte_t lower_limit_low_byte_next =
    wr_lower_low ? SFR_WDATA : lower_limit_low_byte_reg;
  wire adc_fmt_pkg::byte_t lower_limit_high_byte_next =
    wr_lower_high ? SFR_WDATA : lower_limit_high_byte_reg;

  // Limit byte registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      upper_limit_low_byte_reg  <= `RST_UPPER_LIMIT;
      upper_limit_high_byte_reg <= `RST_UPPER_LIMIT;
      lower_limit_low_byte_reg  <= `RST_LOWER_LIMIT;
      lower_limit_high_byte_reg <= `RST_LOWER_LIMIT;
    end else begin
      upper_limit_low_byte_reg  <= upper_limit_low_byte_next;
      upper_limit_high_byte_reg <= upper_limit_high_byte_next;
      lower_limit_low_byte_reg  <= lower_limit_low_byte_next;
      lower_limit_high_byte_reg <= lower_limit_high_byte_next;
    end
  end

  // Read decode; the result bytes have no write decode, so writes to them are ignored
  wire logic rd_upper_low   = SFR_ADDR == `OFS_UPPER_LIMIT_LOW;
  wire logic rd_upper_high  = SFR_ADDR == `OFS_UPPER_LIMIT_HIGH;
  wire logic rd_lower_low   = SFR_ADDR == `OFS_LOWER_LIMIT_LOW;
  wire logic rd_lower_high  = SFR_ADDR == `OFS_LOWER_LIMIT_HIGH;
  wire logic rd_result_low  = SFR_ADDR == `OFS_RESULT_LOW;
  wire logic rd_result_high = SFR_ADDR == `OFS_RESULT_HIGH;
  wire logic rd_control     = SFR_ADDR == `OFS_CONTROL;

  // Control read view; busy is the synchronised copy, so it lags the pin by two cycles
  wire logic [7:0] control_rd = {2'b00, conversion_done_flag_reg, busy_sync_reg,
                                 2'b00, window_compare_flag_reg, justify_select_reg};

  // Read mux as an AND-OR tree; unmapped addresses select nothing and read zero
  assign SFR_RDATA = ({8{rd_upper_low}}   & upper_limit_low_byte_reg)
                   | ({8{rd_upper_high}}  & upper_limit_high_byte_reg)
                   | ({8{rd_lower_low}}   & lower_limit_low_byte_reg)
                   | ({8{rd_lower_high}}  & lower_limit_high_byte_reg)
                   | ({8{rd_result_low}}  & data_word[7:0])
                   | ({8{rd_result_high}} & data_word[15:8])
                   | ({8{rd_control}}     & control_rd);

  assign WINDOW_COMPARE_FLAG  = window_compare_flag_reg;
  assign CONVERSION_DONE_FLAG = conversion_done_flag_reg;

endmodule : adc_result_format_window_compare

// *** bench/adc_fmt_assertions.sv ***
// Port-level checks of the result formatter
`timescale 1ns/10ps
module adc_fmt_assertions (
  input logic       CLOCK,
  input logic       RST_N,
  input logic [7:0] SFR_ADDR,
  input logic       SFR_WR,
  input logic [7:0] SFR_WDATA,
  input logic [7:0] SFR_RDATA,
  input logic       CONVERSION_BUSY,
  input logic       WINDOW_COMPARE_FLAG,
  input logic       CONVERSION_DONE_FLAG
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Control writes and the decoded address map
  wire ctl_wr = SFR_WR && SFR_ADDR == 8'hE8;
  wire mapped = SFR_ADDR inside {8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8};
  // Two sync stages put the flags three edges behind the busy fall
  sequence s_fall; CONVERSION_BUSY ##1 !CONVERSION_BUSY; endsequence
  sequence s_cause; $past(CONVERSION_BUSY, 4) && !$past(CONVERSION_BUSY, 3); endsequence
  property p_done; s_fall |-> ##3 CONVERSION_DONE_FLAG; endproperty
  a_done: assert property (p_done) else $error("done flag late");
  property p_done_cause; $rose(CONVERSION_DONE_FLAG) |-> s_cause; endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without busy fall");
  property p_win_cause; $rose(WINDOW_COMPARE_FLAG) |-> s_cause; endproperty
  a_win_cause: assert property (p_win_cause) else $error("window flag off time");
  property p_win_keep; WINDOW_COMPARE_FLAG && !(ctl_wr && !SFR_WDATA[1]) |=> WINDOW_COMPARE_FLAG;
  endproperty
  a_win_keep: assert property (p_win_keep) else $error("window flag dropped");
  property p_done_keep; CONVERSION_DONE_FLAG && !(ctl_wr && !SFR_WDATA[5]) |=> CONVERSION_DONE_FLAG;
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done flag dropped");
  property p_ctl_read; SFR_ADDR == 8'hE8 |-> SFR_RDATA[1] == WINDOW_COMPARE_FLAG
    && SFR_RDATA[5] == CONVERSION_DONE_FLAG && SFR_RDATA[7:6] == 2'h0 && SFR_RDATA[3:2] == 2'h0;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");
  property p_unmapped; !mapped |-> SFR_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_limit_wb; SFR_WR && SFR_ADDR[7:2] == 6'h31 ##1 $stable(SFR_ADDR)
    |-> SFR_RDATA == $past(SFR_WDATA); endproperty
  a_limit_wb: assert property (p_limit_wb) else $error("limit not stored");
endmodule : adc_fmt_assertions

// *** bench/conv_core_model.sv ***
// Behavioural converter core feeding results to the formatter
`timescale 1ns/10ps
module conv_core_model (
  input  logic       CLOCK,
  input  logic       go,
  input  logic [9:0] code,
  input  logic       diff,
  input  int         slow,
  output logic       busy = 1'b0,
  output logic [9:0] result = 10'h2AA,
  output logic       differential = 1'b0
);
  // Result is only valid from busy fall for five cycles; garbage otherwise
  always @(posedge go) begin
    @(negedge CLOCK);
    busy = 1'b1;
    result = ~code;
    differential = ~diff;
    repeat (slow) @(negedge CLOCK);
    result = code;
    differential = diff;
    busy = 1'b0;
    repeat (5) @(negedge CLOCK);
    result = ~code;
    differential = ~diff;
  end
endmodule : conv_core_model

// *** bench/testbench.sv ***
// Self-checking bench for the result formatter and window comparator
`timescale 1ns/10ps
module testbench;
  logic       clock = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, go = 1'b0, diff = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic       busy, differential, win_flag, done_flag;
  logic [9:0] result, code = 10'h000;
  int         slow = 3, failures = 0, num_checks = 0, cycles = 0;
  conv_core_model core (.CLOCK(clock), .go(go), .code(code), .diff(diff), .slow(slow),
    .busy(busy), .result(result), .differential(differential));
  adc_result_format_window_compare uut (.CLOCK(clock), .RST_N(rst_n), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .CONVERSION_BUSY(busy),
    .CONV_RESULT(result), .DIFFERENTIAL(differential), .WINDOW_COMPARE_FLAG(win_flag),
    .CONVERSION_DONE_FLAG(done_flag));
  initial forever #2.5 clock = ~clock;
  // Hang guard, far above the roughly 190 cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test;
    end
  end
  task end_of_test;
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(input string n, input adc_fmt_pkg::word_t e, input adc_fmt_pkg::word_t g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task chk_pin(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin
  // Strobe held one full cycle, then low a cycle before any next write
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    sfr_addr = a;
    #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, sfr_rdata});
  endtask : rd
  // Control write clears both flags, so each conversion starts clean
  task run(input logic [9:0] c, input logic d, input logic j, input logic [15:0] gt,
           input logic [15:0] lt, input logic [15:0] w, input logic win);
    wr(8'hE8, {7'h00, j});
    wr(8'hC5, gt[15:8]);
    wr(8'hC4, gt[7:0]);
    wr(8'hC7, lt[15:8]);
    wr(8'hC6, lt[7:0]);
    @(negedge clock);
    {code, diff, go} = {c, d, 1'b1};
    @(negedge clock);
    go = 1'b0;
    for (int n = 0; n < 40 && done_flag !== 1'b1; n++) @(negedge clock);
    rd(8'hBF, w[15:8]);
    rd(8'hBE, w[7:0]);
    rd(8'hE8, {2'h0, 1'b1, 3'h0, win, j});
    chk_pin("window flag pin", win, win_flag);
    chk_pin("done flag pin", 1'b1, done_flag);
  endtask : run
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    rd(8'hC4, 8'hFF);
    rd(8'hC5, 8'hFF);
    rd(8'hC7, 8'h00);
    rd(8'hE8, 8'h00);
    rd(8'hC3, 8'h00);
    wr(8'hBF, 8'h5A);
    rd(8'hBF, 8'h00);
    run(10'h3FF, 0, 0, 16'h0200, 16'h0100, 16'h03FF, 1);
    wr(8'hE8, 8'h23);
    rd(8'hE8, 8'h23);
    rd(8'hBF, 8'hFF);
    rd(8'hBE, 8'hC0);
    wr(8'hE8, 8'h20);
    rd(8'hE8, 8'h20);
    chk_pin("window flag cleared", 1'b0, win_flag);
    run(10'h3FF, 0, 1, 16'h8000, 16'h4000, 16'hFFC0, 1);
    run(10'h200, 0, 0, 16'h0200, 16'h0100, 16'h0200, 0);
    run(10'h180, 0, 0, 16'h0100, 16'h0200, 16'h0180, 1);
    slow = 9;
    run(10'h200, 1, 0, 16'h0100, 16'hFF00, 16'hFE00, 1);
    run(10'h200, 1, 1, 16'hFFC0, 16'h2000, 16'h8000, 0);
    run(10'h3FF, 1, 0, 16'h0100, 16'hFF00, 16'hFFFF, 0);
    end_of_test;
  end
endmodule : testbench
bind adc_result_format_window_compare adc_fmt_assertions chk_i (.CLOCK(CLOCK), .RST_N(RST_N),
  .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
  .CONVERSION_BUSY(CONVERSION_BUSY), .WINDOW_COMPARE_FLAG(WINDOW_COMPARE_FLAG),
  .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG));
